// *** suart_pkg.sv ***
package suart_pkg;
	// ======================================
	// register map (byte addresses, one word each)
	localparam logic [7:0] ADDR_DATA    = 8'h00;
	localparam logic [7:0] ADDR_CTRL    = 8'h04;
	localparam logic [7:0] ADDR_TIMER   = 8'h08;
	localparam logic [7:0] ADDR_STATUS  = 8'h0c;
	localparam logic [7:0] ADDR_IRQ_EN  = 8'h10;
	localparam logic [7:0] ADDR_IRQ_CLR = 8'h14;
	// ======================================
	// serial_control field positions
	localparam int CTL_TX_DONE  = 0;
	localparam int CTL_RX_DONE  = 1;
	localparam int CTL_RX_NINTH = 2;
	localparam int CTL_TX_NINTH = 3;
	localparam int CTL_RX_EN    = 4;
	localparam int CTL_MCE      = 5;
	localparam int CTL_MODE9    = 7;
	localparam logic [7:0] CTL_RESET = 8'h00;
	// timer control field positions
	localparam int TMR_RELOAD_LSB = 0;
	localparam int TMR_RUN        = 8;
	localparam int TMR_SRC_LSB    = 12;
	localparam logic [2:0] SRC_SYSTEM_CLOCK   = 3'h0;
	localparam logic [2:0] SRC_DIV12    = 3'h1;
	localparam logic [2:0] SRC_DIV4     = 3'h2;
	localparam logic [2:0] SRC_DIV48    = 3'h3;
	localparam logic [2:0] SRC_EXTOSC8  = 3'h4;
	localparam logic [2:0] SRC_EXTPIN   = 3'h5;
	// prescaler divisors
	localparam logic [5:0] DIV_12 = 6'h0c;
	localparam logic [5:0] DIV_4  = 6'h04;
	localparam logic [5:0] DIV_48 = 6'h30;
	localparam logic [2:0] DIV_8  = 3'h7;
	// frame lengths in bits after the start bit
	localparam logic [3:0] BITS_8  = 4'h9;
	localparam logic [3:0] BITS_9  = 4'ha;
	localparam logic [3:0] DATA_BITS = 4'h8;
	typedef enum logic [1:0] {SU_IDLE, SU_START, SU_SHIFT} suart_state_e;
endpackage

// *** suart_timer.sv ***
// 8-bit auto-reload counter; overflow pulse, divided by two into a bit tick
module suart_timer
	import suart_pkg::*;
(
	input  wire logic       sys_clk,
	input  wire logic       sys_rst,
	input  wire logic       count_en,
	input  wire logic       run,
	input  wire logic [7:0] reload,
	input  wire logic       force_reload,
	output logic            overflow,
	output logic            half_tick,
	output logic            bit_tick
);
	logic [7:0] count;
	logic       phase;

	// ======================================
	// counter: rate = input / (256 - reload)
	assign overflow = run && count_en && (count == 8'hff);
	always_ff @(posedge sys_clk)
	begin
		if (sys_rst || force_reload)
			count <= reload;
		else if (run && count_en)
			count <= overflow ? reload : count + 8'h01;
	end

	// divide-by-two; half_tick lands mid-bit, bit_tick at bit end
	always_ff @(posedge sys_clk)
	begin
		if (sys_rst || force_reload)
			phase <= 1'b0;
		else if (overflow)
			phase <= ~phase;
	end
	assign half_tick = overflow && !phase;
	assign bit_tick  = overflow && phase;
endmodule

// *** suart_core.sv ***
// Behaviour
// - full duplex, independent tx and rx, 8-bit and 9-bit frames
// - received byte is buffered so the next frame may shift in
// - every write to data address loads tx register and requests a frame; writes before it starts share one frame
// - data address read returns the receive buffer, never tx data
// - interrupt requested on tx done or rx done when enabled
// - done flags stay set until software clears them
// - tx bit clock from overflows of timer1_low_count in auto-reload mode
// - hidden rx copy of counter runs with timer, same reload byte
// - both overflow streams divided by two for bit rates
// - start edge on receive line forces rx copy reload
// - timer clock from six sources including system clock, /12, ext/8, pin
// - overflow rate is input clock over 256 minus reload
// - 8-bit frame: start, 8 data lsb first, stop into rx_ninth_bit
// - 9-bit frame: start, 8 data, tx_ninth_bit, stop; ninth to rx_ninth_bit
// - transmit_done_flag set at start of stop bit time
// - load and set rx flag only if flag clear and, when mce is set, check bit passes
module suart_core
	import suart_pkg::*;
(
	input  wire logic        sys_clk,
	input  wire logic        sys_rst,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        rx_pin,
	output logic             tx_pin,
	input  wire logic        ext_osc_clk,
	input  wire logic        timer1_ext_input,
	output logic             irq
);
	// ======================================
	// pin synchronisers
	logic [1:0] rx_sync;
	logic [1:0] osc_sync;
	logic [1:0] t1_sync;
	logic       rx_s;
	logic       osc_d;
	logic       t1_d;
	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			rx_sync  <= 2'h3;
			osc_sync <= 2'h0;
			t1_sync  <= 2'h0;
		end
		else
		begin
			rx_sync  <= {rx_sync[0], rx_pin};
			osc_sync <= {osc_sync[0], ext_osc_clk};
			t1_sync  <= {t1_sync[0], timer1_ext_input};
		end
	end
	assign rx_s = rx_sync[1];

	// edge history of synchronised pins
	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			osc_d <= 1'b0;
			t1_d  <= 1'b0;
		end
		else
		begin
			osc_d <= osc_sync[1];
			t1_d  <= t1_sync[1];
		end
	end

	// ======================================
	// registers
	logic [7:0]  serial_control;
	logic [7:0]  timer1_reload_byte;
	logic        timer_run;
	logic [2:0]  clk_src;
	logic [1:0]  irq_en;
	logic [7:0]  rx_buffer;
	logic        wr_en;
	logic        rd_en;
	logic        set_tx_done;
	logic        set_rx_done;
	logic [8:0]  rx_shift;
	logic        hw_rx_ninth;
	logic [1:0]  status;

	assign wr_en   = psel && penable && pwrite;
	assign rd_en   = psel && penable && !pwrite;
	assign pready  = 1'b1;
	assign pslverr = 1'b0;
	assign status  = {serial_control[CTL_RX_DONE], serial_control[CTL_TX_DONE]};

	// flags: hardware set wins over software clear
	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
			serial_control <= CTL_RESET;
		else
		begin
			if (wr_en && paddr == ADDR_CTRL)
				serial_control <= pwdata[7:0];
			if (wr_en && paddr == ADDR_IRQ_CLR)
			begin
				if (pwdata[0])
					serial_control[CTL_TX_DONE] <= 1'b0;
				if (pwdata[1])
					serial_control[CTL_RX_DONE] <= 1'b0;
			end
			if (set_rx_done)
				serial_control[CTL_RX_NINTH] <= hw_rx_ninth;
			if (set_tx_done)
				serial_control[CTL_TX_DONE] <= 1'b1;
			if (set_rx_done)
				serial_control[CTL_RX_DONE] <= 1'b1;
		end
	end

	// timer and interrupt enable registers
	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			timer1_reload_byte <= 8'h00;
			timer_run          <= 1'b0;
			clk_src            <= SRC_SYSTEM_CLOCK;
			irq_en             <= 2'h0;
		end
		else if (wr_en && paddr == ADDR_TIMER)
		begin
			timer1_reload_byte <= pwdata[TMR_RELOAD_LSB +: 8];
			timer_run          <= pwdata[TMR_RUN];
			clk_src            <= pwdata[TMR_SRC_LSB +: 3];
		end
		else if (wr_en && paddr == ADDR_IRQ_EN)
			irq_en <= pwdata[1:0];
	end

	// read mux; tx holding register is deliberately not readable
	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
			prdata <= 32'h0;
		else if (psel && !penable && !pwrite)
		begin
			case (paddr)
				ADDR_DATA:   prdata <= {24'h0, rx_buffer};
				ADDR_CTRL:   prdata <= {24'h0, serial_control | 8'h40};
				ADDR_TIMER:  prdata <= {17'h0, clk_src, 3'h0, timer_run, timer1_reload_byte};
				ADDR_STATUS: prdata <= {30'h0, status};
				ADDR_IRQ_EN: prdata <= {30'h0, irq_en};
				default:     prdata <= 32'h0;
			endcase
		end
	end

	// interrupt while an enabled done flag is set
	assign irq = |(status & irq_en);

	// ======================================
	// timer input clock selection
	logic [5:0] pre_cnt;
	logic [2:0] osc_cnt;
	logic       osc_rise;
	logic       count_en;
	logic [5:0] pre_div;
	assign osc_rise = osc_sync[1] && !osc_d;

	// shared prescaler; divisor follows selected source
	always_comb
	begin
		case (clk_src)
			SRC_DIV4:  pre_div = DIV_4;
			SRC_DIV48: pre_div = DIV_48;
			default:   pre_div = DIV_12;
		endcase
	end
	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
			pre_cnt <= 6'h0;
		else
			pre_cnt <= (pre_cnt >= pre_div - 6'h01) ? 6'h0 : pre_cnt + 6'h01;
	end
	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
			osc_cnt <= 3'h0;
		else if (osc_rise)
			osc_cnt <= osc_cnt + 3'h1;
	end

	// six sources, each a one-cycle enable
	always_comb
	begin
		case (clk_src)
			SRC_SYSTEM_CLOCK:  count_en = 1'b1;
			SRC_DIV12,
			SRC_DIV4,
			SRC_DIV48:   count_en = (pre_cnt == 6'h0);
			SRC_EXTOSC8: count_en = osc_rise && (osc_cnt == DIV_8);
			SRC_EXTPIN:  count_en = t1_sync[1] && !t1_d;
			default:     count_en = 1'b0;
		endcase
	end

	// ======================================
	// tx and rx baud timers
	logic tx_ovf;
	logic tx_tick;
	logic rx_half;
	logic rx_tick;
	logic rx_reload;

	// tx clock from the visible low counter
	suart_timer u_tx_timer (
		.sys_clk      (sys_clk),
		.sys_rst      (sys_rst),
		.count_en     (count_en),
		.run          (timer_run),
		.reload       (timer1_reload_byte),
		.force_reload (1'b0),
		.overflow     (tx_ovf),
		.half_tick    (),
		.bit_tick     (tx_tick)
	);

	// hidden rx copy, realigned on each start edge
	suart_timer u_rx_timer (
		.sys_clk      (sys_clk),
		.sys_rst      (sys_rst),
		.count_en     (count_en),
		.run          (timer_run),
		.reload       (timer1_reload_byte),
		.force_reload (rx_reload),
		.overflow     (),
		.half_tick    (rx_half),
		.bit_tick     (rx_tick)
	);

	// ======================================
	// transmitter
	suart_state_e tx_state;
	logic [9:0]   tx_shift;
	logic [3:0]   tx_left;
	logic         tx_pend;
	logic [7:0]   tx_hold;

	// write latches a frame request; writes made before the frame starts merge into one frame
	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			tx_pend <= 1'b0;
			tx_hold <= 8'h0;
		end
		else if (wr_en && paddr == ADDR_DATA)
		begin
			tx_pend <= 1'b1;
			tx_hold <= pwdata[7:0];
		end
		else if (tx_state == SU_IDLE && tx_tick)
			tx_pend <= 1'b0;
	end

	// frames start on a bit boundary so bit widths are whole
	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			tx_state <= SU_IDLE;
			tx_pin   <= 1'b1;
			tx_shift <= 10'h3ff;
			tx_left  <= 4'h0;
		end
		else if (tx_tick)
		begin
			case (tx_state)
				SU_IDLE:
				begin
					tx_pin <= 1'b1;
					if (tx_pend)
					begin
						tx_pin   <= 1'b0;
						tx_state <= SU_SHIFT;
						// lsb first; ninth then stop
						tx_shift <= serial_control[CTL_MODE9] ?
							{1'b1, serial_control[CTL_TX_NINTH], tx_hold} :
							{2'b11, tx_hold};
						tx_left  <= serial_control[CTL_MODE9] ? BITS_9 : BITS_8;
					end
				end
				SU_SHIFT:
				begin
					tx_pin   <= tx_shift[0];
					tx_shift <= {1'b1, tx_shift[9:1]};
					tx_left  <= tx_left - 4'h1;
					if (tx_left == 4'h1)
						tx_state <= SU_IDLE;
				end
				default: tx_state <= SU_IDLE;
			endcase
		end
	end
	// done pulses as the stop bit begins
	assign set_tx_done = tx_tick && tx_state == SU_SHIFT && tx_left == 4'h1;

	// ======================================
	// receiver
	suart_state_e rx_state;
	logic [3:0]   rx_left;
	logic         rx_prev;
	logic         rx_last;
	logic         rx_check;
	logic         rx_accept;

	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
			rx_prev <= 1'b1;
		else
			rx_prev <= rx_s;
	end
	assign rx_reload = rx_state == SU_IDLE && serial_control[CTL_RX_EN] && rx_prev && !rx_s;

	// last sample is the stop bit; in 9-bit mode the ninth already sits in rx_shift[8]
	assign rx_last     = rx_half && rx_state == SU_SHIFT && rx_left == 4'h1;
	assign hw_rx_ninth = serial_control[CTL_MODE9] ? rx_shift[8] : rx_s;
	assign rx_check    = serial_control[CTL_MODE9] ? rx_shift[8] : rx_s;
	assign rx_accept   = !serial_control[CTL_RX_DONE] && (!serial_control[CTL_MCE] || rx_check);
	assign set_rx_done = rx_last && rx_accept;

	// mid-bit sampling driven by realigned half ticks
	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			rx_state <= SU_IDLE;
			rx_left  <= 4'h0;
			rx_shift <= 9'h0;
		end
		else
		begin
			case (rx_state)
				SU_IDLE:
					if (rx_reload)
						rx_state <= SU_START;
				SU_START:
					if (rx_half)
					begin
						// false start: line back high at mid start bit
						rx_state <= rx_s ? SU_IDLE : SU_SHIFT;
						rx_left  <= serial_control[CTL_MODE9] ? BITS_9 : BITS_8;
					end
				SU_SHIFT:
					if (rx_half)
					begin
						if (rx_left > 4'h1 || serial_control[CTL_MODE9])
							rx_shift <= {rx_s, rx_shift[8:1]};
						rx_left <= rx_left - 4'h1;
						if (rx_left == 4'h1)
							rx_state <= SU_IDLE;
					end
				default: rx_state <= SU_IDLE;
			endcase
		end
	end

	// separate receive buffer; shifter free for the next byte
	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
			rx_buffer <= 8'h0;
		else if (set_rx_done)
			rx_buffer <= serial_control[CTL_MODE9] ? rx_shift[7:0] : rx_shift[8:1];
	end

	// ======================================
	// checks
	tx_idle_high_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(tx_state == SU_IDLE && !$past(tx_tick)) |-> tx_pin == $past(tx_pin)) else $error("tx line moved off tick");
	tx_done_set_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		set_tx_done |=> serial_control[CTL_TX_DONE] && tx_state == SU_IDLE) else $error("tx done not set");
	flag_sticky_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(serial_control[CTL_RX_DONE] && !wr_en) |=> serial_control[CTL_RX_DONE]) else $error("rx flag dropped");
	irq_level_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(serial_control[CTL_TX_DONE] && irq_en[0]) |-> irq) else $error("irq missing");
	rx_block_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(rx_last && serial_control[CTL_RX_DONE]) |=> $stable(rx_buffer)) else $error("rx overwrote buffer");
	rx_load_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		set_rx_done |=> serial_control[CTL_RX_DONE] && rx_state == SU_IDLE) else $error("rx load missing");
	rx_realign_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		rx_reload |=> rx_state == SU_START && !rx_half) else $error("rx timer not realigned");
	tx_start_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(tx_tick && tx_state == SU_IDLE && tx_pend) |=> !tx_pin && tx_state == SU_SHIFT) else $error("frame not started");
	tick_split_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		!(rx_half && rx_tick)) else $error("rx ticks overlap");
	tx_tick_ovf_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		tx_tick |-> tx_ovf) else $error("tx tick without overflow");
endmodule

// *** suart_remote.sv ***
// ======================================
// remote serial node: sends frames on rx_pin, captures frames from tx_pin
module suart_remote
#(
	parameter int BIT = 16
)
(
	input  wire logic       sys_clk,
	input  wire logic       tx_pin,
	input  wire logic       mode9,
	output logic            rx_pin,
	output logic [8:0]      got,
	output logic            got_valid
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [9:0] sh;
	// bit length in clocks; the bench changes it along with the timer source
	int         bit_len = BIT;
	initial
	begin
		rx_pin = 1'b1;
		got = 9'h000;
		got_valid = 1'b0;
	end
	// start low, data lsb first, optional ninth, stop high; line idles high
	task automatic send(input logic [7:0] b, input logic n);
		logic [10:0] f;
		f = mode9 ? {1'b1, n, b, 1'b0} : {2'b11, b, 1'b0};
		for (int i = 0; i < (mode9 ? 11 : 10); i++)
		begin
			@(posedge sys_clk);
			rx_pin <= f[i];
			repeat (bit_len - 1) @(posedge sys_clk);
		end
	endtask
	// sample mid-bit; in 8-bit mode slot 8 is the stop bit, reported as ninth
	always
	begin
		@(negedge tx_pin);
		repeat (bit_len / 2) @(posedge sys_clk);
		for (int i = 0; i < (mode9 ? 10 : 9); i++)
		begin
			repeat (bit_len) @(posedge sys_clk);
			sh[i] = tx_pin;
		end
		got <= sh[8:0];
		got_valid <= 1'b1;
		@(posedge sys_clk);
		got_valid <= 1'b0;
	end
endmodule

// *** suart_core_bench.sv ***
// ======================================
// self-checking bench for the serial core
module suart_core_bench
	import suart_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic        sys_clk;
	logic        sys_rst;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        rx_pin;
	logic        tx_pin;
	logic        ext_osc_clk;
	logic        timer1_ext_input;
	logic        irq;
	logic        mode9;
	logic [8:0]  got;
	logic        got_valid;
	logic [31:0] rdv;
	logic [7:0]  b;
	logic [7:0]  r;
	logic [7:0]  r2;
	int          bad_count;
	int          tests_run;
	int          seed;
	logic [31:0] q_rd[$];
	logic [31:0] q_tx[$];
	event        rd_ev;
	// half-bit lengths: system_clock 8 counts, /12 2 counts, ext osc/8 1 count, /4 2 counts
	// system_clock comes first so the counter leaves its reset value quickly
	localparam logic [31:0] TMR_TAB [4] = '{32'h000001f8, 32'h000011fe, 32'h000041ff, 32'h000021fe};
	localparam int          BIT_TAB [4] = '{16, 48, 32, 16};
	suart_core u_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_pin(rx_pin),
		.tx_pin(tx_pin), .ext_osc_clk(ext_osc_clk), .timer1_ext_input(timer1_ext_input), .irq(irq));
	suart_remote #(.BIT(16)) u_remote (.sys_clk(sys_clk), .tx_pin(tx_pin), .mode9(mode9), .rx_pin(rx_pin),
		.got(got), .got_valid(got_valid));
	// ======================================
	// clock and external clock sources kept moving
	initial
	begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk)
	begin
		ext_osc_clk <= ~ext_osc_clk;
		timer1_ext_input <= 1'($random(seed));
	end
	// ======================================
	// comparison and closing
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e)
		begin
			bad_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic finish_test;
		$display("tests_run=%0d bad_count=%0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// oldest note is matched against each result as it shows up
	always @(rd_ev) chk(rdv, q_rd.pop_front());
	always @(posedge sys_clk)
	begin
		if (got_valid === 1'b1)
			chk({22'h0, irq, got}, q_tx.pop_front());
	end
	// ======================================
	// apb master: hold request until pready seen high at a rising edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		do @(posedge sys_clk); while (pready !== 1'b1);
		rdv = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		q_rd.push_back(e);
		apb(1'b0, a, 32'h0);
		-> rd_ev;
	endtask
	task automatic chk_irq(input logic e);
		@(negedge sys_clk);
		chk({31'h0, irq}, {31'h0, e});
	endtask
	task automatic wait_tx;
		for (int i = 0; i < 1000 && q_tx.size() > 0; i++)
			@(posedge sys_clk);
		// a frame that never came back counts as a mismatch
		if (q_tx.size() > 0)
			bad_count++;
		repeat (4) @(posedge sys_clk);
	endtask
	// ======================================
	// main sequence
	initial
	begin
		seed = 32'h76a9b962;
		{psel, penable, pwrite, paddr, pwdata, mode9} = '0;
		{ext_osc_clk, timer1_ext_input} = 2'b00;
		sys_rst = 1'b1;
		repeat (2) @(posedge sys_clk);
		sys_rst <= 1'b0;
		rd(ADDR_CTRL, 32'h00000040);
		rd(ADDR_STATUS, 32'h0);
		wr(ADDR_IRQ_EN, 32'h3);
		wr(ADDR_CTRL, 32'h10);
		// full duplex frames at four clock sources
		for (int k = 0; k < 4; k++)
		begin
			u_remote.bit_len = BIT_TAB[k];
			wr(ADDR_TIMER, TMR_TAB[k]);
			wr(ADDR_IRQ_CLR, 32'h3);
			b = $random(seed);
			r = $random(seed);
			q_tx.push_back({22'h0, 1'b1, 1'b1, b});
			fork
				wr(ADDR_DATA, {24'h0, b});
				u_remote.send(r, 1'b1);
			join
			wait_tx;
			rd(ADDR_STATUS, 32'h3);
			rd(ADDR_DATA, {24'h0, r});
			rd(ADDR_CTRL, 32'h57);
			chk_irq(1'b1);
			wr(ADDR_IRQ_CLR, 32'h3);
			rd(ADDR_STATUS, 32'h0);
			chk_irq(1'b0);
		end
		// second frame while flag still set is dropped
		r = $random(seed);
		r2 = ~r;
		u_remote.send(r, 1'b1);
		u_remote.send(r2, 1'b1);
		rd(ADDR_DATA, {24'h0, r});
		wr(ADDR_IRQ_EN, 32'h1);
		chk_irq(1'b0);
		wr(ADDR_IRQ_EN, 32'h3);
		chk_irq(1'b1);
		wr(ADDR_IRQ_CLR, 32'h2);
		chk_irq(1'b0);
		// next frame shifts in while software empties the buffer
		u_remote.send(r, 1'b1);
		fork
			u_remote.send(r2, 1'b1);
			begin
				repeat (40) @(posedge sys_clk);
				rd(ADDR_DATA, {24'h0, r});
				wr(ADDR_IRQ_CLR, 32'h2);
			end
		join
		rd(ADDR_DATA, {24'h0, r2});
		// 9-bit frames; address check passes only with ninth bit one
		mode9 = 1'b1;
		for (int n = 0; n < 2; n++)
		begin
			wr(ADDR_CTRL, 32'hb0 | (n << 3));
			b = $random(seed);
			r = $random(seed);
			q_tx.push_back({22'h0, 1'b1, n[0], b});
			fork
				wr(ADDR_DATA, {24'h0, b});
				u_remote.send(r, n[0]);
			join
			wait_tx;
			rd(ADDR_STATUS, {30'h0, n[0], 1'b1});
			if (n == 1)
			begin
				rd(ADDR_DATA, {24'h0, r});
				rd(ADDR_CTRL, 32'hff);
			end
		end
		chk(q_tx.size(), 32'h0);
		rd(8'h20, 32'h0);
		finish_test;
	end
	// watchdog sized well beyond the few thousand cycles the sequence needs
	initial
	begin
		repeat (60000) @(posedge sys_clk);
		bad_count++;
		finish_test;
	end
endmodule
